// >>> cmfe_map.svh
`ifndef CMFE_MAP_SVH
`define CMFE_MAP_SVH

// stored word layout
`define CMFE_DATA_W      64
`define CMFE_CHK_W       8
`define CMFE_WORD_W      72
`define CMFE_POS_HI      71
`define CMFE_SYN_W       7

// peripheral word packing
`define CMFE_PW_W        16
`define CMFE_WORDS_16    3'h4
`define CMFE_WORDS_12    3'h5

// capacity select codes
`define CMFE_CAP_2MB     3'h0
`define CMFE_CAP_4MB     3'h1
`define CMFE_CAP_8MB     3'h2
`define CMFE_CAP_12MB    3'h3
`define CMFE_CAP_16MB    3'h4
`define CMFE_CAP_32MB    3'h5

// maintenance register select
`define CMFE_MREG_CE     2'h0
`define CMFE_MREG_UE     2'h1
`define CMFE_MREG_EADDR  2'h2
`define CMFE_MREG_STAT   2'h3

`endif

// >>> cmfe_pkg.sv
`include "cmfe_map.svh"

package cmfe_pkg;

  typedef enum logic [1:0]
  {
    CMFE_ST_IDLE = 2'b00,
    CMFE_ST_READ = 2'b01,
    CMFE_ST_GAP  = 2'b10
  } cmfe_state_t;

  typedef enum logic
  {
    CMFE_PORT_CPU = 1'b0,
    CMFE_PORT_IO  = 1'b1
  } cmfe_port_t;

  typedef struct packed
  {
    logic [`CMFE_DATA_W-1:0] data;
    logic                    ce;
    logic                    ue;
  } cmfe_rsp_t;

  // hamming positions 1..71, overall parity in bit 0
  function automatic logic [`CMFE_WORD_W-1:0] cmfe_ecc_enc(input logic [`CMFE_DATA_W-1:0] d);
    logic [`CMFE_WORD_W-1:0] cw;
    logic [`CMFE_SYN_W-1:0]  c;
    int                      k;
    cw = '0;
    c  = '0;
    k  = 0;
    for (int p = 1; p <= `CMFE_POS_HI; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        cw[p] = d[k];
        k++;
      end
    end
    for (int i = 0; i < `CMFE_SYN_W; i++)
    begin
      for (int p = 1; p <= `CMFE_POS_HI; p++)
      begin
        if ((p & (1 << i)) != 0)
        begin
          c[i] = c[i] ^ cw[p];
        end
      end
    end
    for (int i = 0; i < `CMFE_SYN_W; i++)
    begin
      cw[1 << i] = c[i];
    end
    cw[0] = ^cw;
    return cw;
  endfunction : cmfe_ecc_enc

  function automatic cmfe_rsp_t cmfe_ecc_dec(input logic [`CMFE_WORD_W-1:0] cw_in);
    logic [`CMFE_WORD_W-1:0] cw;
    logic [`CMFE_SYN_W-1:0]  syn;
    logic                    par;
    cmfe_rsp_t               r;
    int                      k;
    cw  = cw_in;
    syn = '0;
    k   = 0;
    r   = '0;
    for (int i = 0; i < `CMFE_SYN_W; i++)
    begin
      for (int p = 1; p <= `CMFE_POS_HI; p++)
      begin
        if ((p & (1 << i)) != 0)
        begin
          syn[i] = syn[i] ^ cw[p];
        end
      end
    end
    par = ^cw;
    if (par && (int'(syn) <= `CMFE_POS_HI))
    begin
      cw[syn] = ~cw[syn];
      r.ce    = 1'b1;
    end
    else if (syn != '0)
    begin
      r.ue = 1'b1;
    end
    for (int p = 1; p <= `CMFE_POS_HI; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        r.data[k] = cw[p];
        k++;
      end
    end
    return r;
  endfunction : cmfe_ecc_dec

endpackage : cmfe_pkg

// >>> cmfe_store.sv
`timescale 1ns/1ps
`default_nettype none

module cmfe_store
  import cmfe_pkg::*;
#(
  parameter int AW = 16,
  parameter int W  = 72
)
(
  // clock
  input  wire logic          clk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata_q
);

  logic [W-1:0] mem [0:(2**AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (re)
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : cmfe_store

`default_nettype wire

// >>> cmfe_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "cmfe_map.svh"

// Functional notes
// - pack four 16-bit peripheral words into one memory word, or all five 12-bit words into its low 60 bits.
// - split a memory word into five 12-bit or four 16-bit peripheral words.
// - exactly two request ports, processor port and io unit port.
// - arbitrate simultaneous requests, mux winner to storage, no port locked out.
// - compute check bits on every write and store them with the word.
// - check every read, correct single-bit errors, flag double-bit errors.
// - consecutive word addresses fall in consecutive banks.
// - two banks at 2 MB capacity, four banks for all larger sizes.
// - maintenance channel reads error counters and status, and clears counters.
// - each stored word is 72 bits, 64 data plus 8 check bits.
module cmfe_top
  import cmfe_pkg::*;
#(
  parameter int AW = 16
)
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // configuration
  input  wire logic [2:0]              cap_sel,
  input  wire logic                    word12,
  // processor port
  input  wire logic                    cpu_req,
  input  wire logic                    cpu_we,
  input  wire logic [AW-1:0]           cpu_addr,
  input  wire logic [`CMFE_DATA_W-1:0] cpu_wdata,
  output var  logic                    cpu_gnt_q,
  output var  logic                    cpu_rvalid_q,
  output var  logic [`CMFE_DATA_W-1:0] cpu_rdata_q,
  // io unit port, words toward memory
  input  wire logic                    pw_valid,
  input  wire logic [`CMFE_PW_W-1:0]   pw_data,
  input  wire logic [AW-1:0]           pw_addr,
  output var  logic                    pw_ready_q,
  // io unit port, words from memory
  input  wire logic                    io_rd_req,
  input  wire logic [AW-1:0]           io_rd_addr,
  output var  logic                    io_rd_gnt_q,
  output var  logic                    po_valid_q,
  output var  logic [`CMFE_PW_W-1:0]   po_data_q,
  // read check report
  output var  logic                    ecc_ce_q,
  output var  logic                    ecc_ue_q,
  output var  logic [1:0]              bank_q,
  // maintenance channel
  input  wire logic                    maint_rd,
  input  wire logic                    maint_clr,
  input  wire logic [1:0]              maint_sel,
  output var  logic                    maint_rvalid_q,
  output var  logic [31:0]             maint_rdata_q
);

  function automatic logic [2:0] words_of(input logic w12);
    return w12 ? `CMFE_WORDS_12 : `CMFE_WORDS_16;
  endfunction : words_of

  // bank in the low address bits, row above it
  function automatic logic [AW-1:0] store_index(input logic [AW-1:0] a, input logic [2:0] cap);
    if (cap == `CMFE_CAP_2MB)
    begin
      return {a[0], a[AW-1:1]};
    end
    return {a[1:0], a[AW-1:2]};
  endfunction : store_index

  cmfe_state_t             st_q;
  cmfe_port_t              prio_q;
  cmfe_port_t              rd_port_q;
  logic [2:0]              pk_cnt_q;
  logic                    pk_full_q;
  logic [`CMFE_DATA_W-1:0] pk_data_q;
  logic [AW-1:0]           pk_addr_q;
  logic [2:0]              up_cnt_q;
  logic [`CMFE_DATA_W-1:0] up_data_q;
  logic [AW-1:0]           rd_addr_q;
  logic [AW-1:0]           err_addr_q;
  logic [15:0]             ce_cnt_q;
  logic [15:0]             ue_cnt_q;
  logic                    io_req;
  logic                    gnt_cpu;
  logic                    gnt_io;
  logic                    acc_we;
  logic [AW-1:0]           acc_addr;
  logic [1:0]              acc_lo;
  logic [`CMFE_DATA_W-1:0] acc_data;
  logic [`CMFE_WORD_W-1:0] st_wcw;
  logic [`CMFE_WORD_W-1:0] st_rcw;
  logic                    st_we;
  logic                    st_re;
  cmfe_rsp_t               rsp;
  cmfe_rsp_t               wr_chk;
  cmfe_rsp_t               wr_one;
  cmfe_rsp_t               wr_two;

  // arbitration and access mux
  always_comb
  begin
    io_req   = pk_full_q || (io_rd_req && (up_cnt_q == 3'h0));
    gnt_cpu  = (st_q == CMFE_ST_IDLE) && cpu_req && (!io_req || (prio_q == CMFE_PORT_CPU));
    gnt_io   = (st_q == CMFE_ST_IDLE) && io_req && !gnt_cpu;
    acc_we   = gnt_cpu ? cpu_we : pk_full_q;
    acc_addr = gnt_cpu ? cpu_addr : (pk_full_q ? pk_addr_q : io_rd_addr);
    acc_lo   = acc_addr[1:0];
    acc_data = gnt_cpu ? cpu_wdata : pk_data_q;
    st_we    = (gnt_cpu || gnt_io) && acc_we;
    st_re    = (gnt_cpu || gnt_io) && !acc_we;
    st_wcw   = cmfe_ecc_enc(acc_data);
    rsp      = cmfe_ecc_dec(st_rcw);
  end

  cmfe_store #(
    .AW (AW),
    .W  (`CMFE_WORD_W)
  ) u_store (
    .clk     (clk),
    .we      (st_we),
    .waddr   (store_index(acc_addr, cap_sel)),
    .wdata   (st_wcw),
    .re      (st_re),
    .raddr   (store_index(acc_addr, cap_sel)),
    .rdata_q (st_rcw)
  );

  // access sequencing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q      <= CMFE_ST_IDLE;
      prio_q    <= CMFE_PORT_CPU;
      rd_port_q <= CMFE_PORT_CPU;
      rd_addr_q <= '0;
      bank_q    <= 2'h0;
    end
    else
    begin
      case (st_q)
        CMFE_ST_IDLE:
        begin
          if (gnt_cpu || gnt_io)
          begin
            st_q      <= acc_we ? CMFE_ST_GAP : CMFE_ST_READ;
            prio_q    <= gnt_cpu ? CMFE_PORT_IO : CMFE_PORT_CPU;
            rd_port_q <= gnt_cpu ? CMFE_PORT_CPU : CMFE_PORT_IO;
            rd_addr_q <= acc_addr;
            bank_q    <= (cap_sel == `CMFE_CAP_2MB) ? {1'b0, acc_addr[0]} : acc_addr[1:0];
          end
        end
        CMFE_ST_READ: st_q <= CMFE_ST_IDLE;
        CMFE_ST_GAP:  st_q <= CMFE_ST_IDLE;
        default:      st_q <= CMFE_ST_IDLE;
      endcase
    end
  end

  // grants and processor read return
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_gnt_q    <= 1'b0;
      io_rd_gnt_q  <= 1'b0;
      cpu_rvalid_q <= 1'b0;
      cpu_rdata_q  <= '0;
      ecc_ce_q     <= 1'b0;
      ecc_ue_q     <= 1'b0;
    end
    else
    begin
      cpu_gnt_q    <= gnt_cpu;
      io_rd_gnt_q  <= gnt_io && !pk_full_q;
      cpu_rvalid_q <= (st_q == CMFE_ST_READ) && (rd_port_q == CMFE_PORT_CPU);
      ecc_ce_q     <= (st_q == CMFE_ST_READ) && rsp.ce;
      ecc_ue_q     <= (st_q == CMFE_ST_READ) && rsp.ue;
      if ((st_q == CMFE_ST_READ) && (rd_port_q == CMFE_PORT_CPU))
      begin
        cpu_rdata_q <= rsp.data;
      end
    end
  end

  // word packer, io words toward memory
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pk_cnt_q   <= 3'h0;
      pk_full_q  <= 1'b0;
      pw_ready_q <= 1'b1;
      pk_data_q  <= '0;
      pk_addr_q  <= '0;
    end
    else if (gnt_io && pk_full_q)
    begin
      pk_full_q  <= 1'b0;
      pw_ready_q <= 1'b1;
    end
    else if (pw_valid && pw_ready_q)
    begin
      pk_data_q <= word12 ? {4'h0, pk_data_q[47:0], pw_data[11:0]}
                          : {pk_data_q[47:0], pw_data};
      if (pk_cnt_q == 3'h0)
      begin
        pk_addr_q <= pw_addr;
      end
      if (pk_cnt_q == (words_of(word12) - 3'h1))
      begin
        pk_cnt_q   <= 3'h0;
        pk_full_q  <= 1'b1;
        pw_ready_q <= 1'b0;
      end
      else
      begin
        pk_cnt_q <= pk_cnt_q + 3'h1;
      end
    end
  end

  // word splitter, memory word toward io
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      up_cnt_q   <= 3'h0;
      up_data_q  <= '0;
      po_valid_q <= 1'b0;
      po_data_q  <= '0;
    end
    else if ((st_q == CMFE_ST_READ) && (rd_port_q == CMFE_PORT_IO))
    begin
      up_cnt_q   <= words_of(word12);
      up_data_q  <= rsp.data;
      po_valid_q <= 1'b0;
    end
    else if (up_cnt_q != 3'h0)
    begin
      po_valid_q <= 1'b1;
      po_data_q  <= word12 ? {4'h0, up_data_q[59:48]} : up_data_q[63:48];
      up_data_q  <= word12 ? {up_data_q[51:0], 12'h000} : {up_data_q[47:0], 16'h0000};
      up_cnt_q   <= up_cnt_q - 3'h1;
    end
    else
    begin
      po_valid_q <= 1'b0;
    end
  end

  // maintenance counters, a clear with an event in the same cycle leaves a count of one
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ce_cnt_q   <= 16'h0000;
      ue_cnt_q   <= 16'h0000;
      err_addr_q <= '0;
    end
    else
    begin
      if ((st_q == CMFE_ST_READ) && rsp.ce)
      begin
        ce_cnt_q <= maint_clr ? 16'h0001 : ce_cnt_q + 16'h0001;
      end
      else if (maint_clr)
      begin
        ce_cnt_q <= 16'h0000;
      end
      if ((st_q == CMFE_ST_READ) && rsp.ue)
      begin
        ue_cnt_q <= maint_clr ? 16'h0001 : ue_cnt_q + 16'h0001;
      end
      else if (maint_clr)
      begin
        ue_cnt_q <= 16'h0000;
      end
      if ((st_q == CMFE_ST_READ) && (rsp.ce || rsp.ue))
      begin
        err_addr_q <= rd_addr_q;
      end
    end
  end

  // maintenance read port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      maint_rvalid_q <= 1'b0;
      maint_rdata_q  <= 32'h00000000;
    end
    else
    begin
      maint_rvalid_q <= maint_rd;
      if (maint_rd)
      begin
        case (maint_sel)
          `CMFE_MREG_CE:    maint_rdata_q <= {16'h0000, ce_cnt_q};
          `CMFE_MREG_UE:    maint_rdata_q <= {16'h0000, ue_cnt_q};
          `CMFE_MREG_EADDR: maint_rdata_q <= {{(32-AW){1'b0}}, err_addr_q};
          `CMFE_MREG_STAT:  maint_rdata_q <= {24'h000000, cap_sel, word12, prio_q, 1'b0, st_q};
          default:          maint_rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // outgoing word decoded clean, with one and with two flipped bits
  always_comb
  begin
    wr_chk = cmfe_ecc_dec(st_wcw);
    wr_one = cmfe_ecc_dec(st_wcw ^ 72'h8);
    wr_two = cmfe_ecc_dec(st_wcw ^ 72'h28);
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_burst4;
    po_valid_q [*4] ##1 !po_valid_q;
  endsequence

  sequence s_burst5;
    po_valid_q [*5] ##1 !po_valid_q;
  endsequence

  sequence s_io_load;
    (st_q == CMFE_ST_READ) && (rd_port_q == CMFE_PORT_IO);
  endsequence

  a_pack_fill: assert property (pw_valid && pw_ready_q && !(gnt_io && pk_full_q)
      && (pk_cnt_q == (words_of(word12) - 3'h1)) |=> pk_full_q && !pw_ready_q)
    else $error("packer did not fill on last word");
  a_split_four: assert property (s_io_load ##0 !word12 |-> ##2 s_burst4)
    else $error("16-bit split not four words");
  a_split_five: assert property (s_io_load ##0 word12 |-> ##2 s_burst5)
    else $error("12-bit split not five words");
  a_grant_single: assert property (!(cpu_gnt_q && io_rd_gnt_q))
    else $error("both ports granted together");
  a_cpu_no_lockout: assert property (cpu_req && !cpu_gnt_q |-> ##[1:3] cpu_gnt_q)
    else $error("processor port starved");
  a_io_no_lockout: assert property (pk_full_q |-> ##[1:4] !pk_full_q)
    else $error("io port starved");
  a_ecc_clean: assert property (st_we |-> !wr_chk.ce
      && !wr_chk.ue && (wr_chk.data == acc_data))
    else $error("written check bits inconsistent");
  a_ecc_fix_one: assert property (st_we |-> wr_one.ce
      && !wr_one.ue && (wr_one.data == acc_data))
    else $error("single flipped bit not corrected");
  a_ecc_flag_two: assert property (st_we |-> wr_two.ue && !wr_two.ce)
    else $error("double flipped bit not flagged");
  a_read_latency: assert property (gnt_cpu && !cpu_we |-> ##2 cpu_rvalid_q)
    else $error("processor read not returned in two cycles");
  a_ce_ue_excl: assert property (!(ecc_ce_q && ecc_ue_q))
    else $error("corrected and uncorrectable both set");
  a_bank_map: assert property ((gnt_cpu || gnt_io) |=> (cap_sel == `CMFE_CAP_2MB)
      ? (bank_q == {1'b0, $past(acc_lo[0])}) : (bank_q == $past(acc_lo)))
    else $error("bank not taken from low address bits");
  a_maint_read: assert property (maint_rd && (maint_sel == `CMFE_MREG_UE)
      |=> maint_rvalid_q && (maint_rdata_q[15:0] == $past(ue_cnt_q)))
    else $error("maintenance read wrong");

endmodule : cmfe_top

`default_nettype wire

// >>> cmfe_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmfe_cpu_model
#(
  parameter int AW = 8
)
(
  // clock
  input  wire logic          clk,
  // request side
  output var  logic          cpu_req,
  output var  logic          cpu_we,
  output var  logic [AW-1:0] cpu_addr,
  output var  logic [63:0]   cpu_wdata,
  // answer side
  input  wire logic          cpu_gnt_q,
  input  wire logic          cpu_rvalid_q,
  input  wire logic [63:0]   cpu_rdata_q
);
  initial
  begin
    cpu_req   = 1'b0;
    cpu_we    = 1'b0;
    cpu_addr  = '0;
    cpu_wdata = '0;
  end

  // one access through the single processor port
  task automatic access(input logic we, input logic [AW-1:0] addr, input logic [63:0] wd,
                        output logic [63:0] rd, output logic ok);
    int n;
    n  = 0;
    rd = '0;
    @(posedge clk);
    cpu_req   <= 1'b1;
    cpu_we    <= we;
    cpu_addr  <= addr;
    cpu_wdata <= wd;
    @(posedge clk);
    // everything held until the grant is sampled
    while (cpu_gnt_q !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    ok = (cpu_gnt_q === 1'b1);
    // released lines show inverted values, never stale ones
    cpu_req   <= 1'b0;
    cpu_we    <= ~we;
    cpu_addr  <= ~addr;
    cpu_wdata <= ~wd;
    if (!we)
    begin
      @(posedge clk);
      ok = ok && (cpu_rvalid_q === 1'b1);
      rd = cpu_rdata_q;
    end
  endtask : access
endmodule : cmfe_cpu_model

`default_nettype wire

// >>> cmfe_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk, rst, word12, cpu_req, cpu_we, cpu_gnt_q, cpu_rvalid_q;
  logic [2:0]  cap_sel;
  logic [7:0]  cpu_addr, pw_addr, io_rd_addr;
  logic [63:0] cpu_wdata, cpu_rdata_q;
  logic        pw_valid, pw_ready_q, io_rd_req, io_rd_gnt_q, po_valid_q;
  logic [15:0] pw_data, po_data_q;
  logic        ecc_ce_q, ecc_ue_q, maint_rd, maint_clr, maint_rvalid_q;
  logic [1:0]  bank_q, maint_sel;
  logic [31:0] maint_rdata_q;
  int          errors;
  int          check_count;

  cmfe_top #(.AW(8)) cmfe_top_i (.clk(clk), .rst(rst), .cap_sel(cap_sel), .word12(word12),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_gnt_q(cpu_gnt_q), .cpu_rvalid_q(cpu_rvalid_q), .cpu_rdata_q(cpu_rdata_q),
    .pw_valid(pw_valid), .pw_data(pw_data), .pw_addr(pw_addr), .pw_ready_q(pw_ready_q),
    .io_rd_req(io_rd_req), .io_rd_addr(io_rd_addr), .io_rd_gnt_q(io_rd_gnt_q),
    .po_valid_q(po_valid_q), .po_data_q(po_data_q), .ecc_ce_q(ecc_ce_q),
    .ecc_ue_q(ecc_ue_q), .bank_q(bank_q), .maint_rd(maint_rd), .maint_clr(maint_clr),
    .maint_sel(maint_sel), .maint_rvalid_q(maint_rvalid_q), .maint_rdata_q(maint_rdata_q));

  cmfe_cpu_model #(.AW(8)) cmfe_cpu_model_i (.clk(clk), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_gnt_q(cpu_gnt_q),
    .cpu_rvalid_q(cpu_rvalid_q), .cpu_rdata_q(cpu_rdata_q));

  always #2 clk = ~clk;

  task automatic check_word(input logic [63:0] act, input logic [63:0] exp);
    check_count++;
    if (act !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask : check_word

  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic rd_chk(input logic [7:0] a, input logic [63:0] exp);
    logic [63:0] rd;
    logic        ok;
    cmfe_cpu_model_i.access(1'b0, a, 64'h0, rd, ok);
    check_word(64'(ok), 64'h1);
    check_word(rd, exp);
    check_word(64'({ecc_ce_q, ecc_ue_q}), 64'h0);
  endtask : rd_chk

  task automatic io_read(input logic [7:0] a, output logic [15:0] got [8], output int k);
    int n;
    n = 0;
    k = 0;
    @(posedge clk);
    io_rd_req  <= 1'b1;
    io_rd_addr <= a;
    @(posedge clk);
    while (io_rd_gnt_q !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    io_rd_req  <= 1'b0;
    io_rd_addr <= ~a;
    repeat (10)
    begin
      @(posedge clk);
      if (po_valid_q === 1'b1 && k < 8)
      begin
        got[k] = po_data_q;
        k++;
      end
    end
  endtask : io_read

  task automatic t_write_read();
    logic [63:0] rd;
    logic        ok;
    cmfe_cpu_model_i.access(1'b1, 8'h10, 64'hA5A5_0F0F_C3C3_9669, rd, ok);
    cmfe_cpu_model_i.access(1'b1, 8'h11, 64'hFFFF_FFFF_FFFF_FFFF, rd, ok);
    rd_chk(8'h10, 64'hA5A5_0F0F_C3C3_9669);
    rd_chk(8'h11, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("test write_read done");
  endtask : t_write_read

  task automatic t_banks();
    logic [63:0] rd;
    logic        ok;
    for (int c = 0; c < 6; c++)
    begin
      for (int a = 4; a < 8; a++)
      begin
        @(posedge clk);
        cap_sel <= 3'(c);
        cmfe_cpu_model_i.access(1'b1, 8'(a), 64'(a), rd, ok);
        @(posedge clk);
        check_word(64'(ok), 64'h1);
        check_word(64'(bank_q), (c == 0) ? 64'(a % 2) : 64'(a % 4));
      end
    end
    $display("test banks done");
  endtask : t_banks

  task automatic t_pack(input logic m12);
    logic [15:0] w [5];
    logic [63:0] exp;
    int          n;
    int          k;
    w   = '{16'hF123, 16'h4567, 16'h89AB, 16'hCDEF, 16'h5A5A};
    n   = m12 ? 5 : 4;
    exp = '0;
    @(posedge clk);
    word12  <= m12;
    pw_addr <= 8'h40;
    for (int i = 0; i < n; i++)
    begin
      exp = m12 ? {exp[51:0], w[i][11:0]} : {exp[47:0], w[i]};
      pw_valid <= 1'b1;
      pw_data  <= w[i];
      k = 0;
      @(posedge clk);
      while (pw_ready_q !== 1'b1 && k < 16)
      begin
        @(posedge clk);
        k++;
      end
    end
    pw_valid <= 1'b0;
    pw_data  <= ~w[n-1];
    pw_addr  <= 8'hBF;
    @(posedge clk);
    check_word(64'(pw_ready_q), 64'h0);
    k = 0;
    while (pw_ready_q !== 1'b1 && k < 16)
    begin
      @(posedge clk);
      k++;
    end
    rd_chk(8'h40, exp);
    $display("test pack done");
  endtask : t_pack

  task automatic t_split(input logic m12);
    logic [63:0] d;
    logic [63:0] rd;
    logic [15:0] got [8];
    logic        ok;
    int          k;
    d = 64'hF123_4567_89AB_CDEF;
    @(posedge clk);
    word12 <= m12;
    cmfe_cpu_model_i.access(1'b1, 8'h21, d, rd, ok);
    io_read(8'h21, got, k);
    check_word(64'(k), m12 ? 64'h5 : 64'h4);
    for (int i = 0; i < k && i < 5; i++)
    begin
      check_word(64'(got[i]), m12 ? 64'(d[59-12*i -: 12]) : 64'(d[63-16*i -: 16]));
    end
    $display("test split done");
  endtask : t_split

  task automatic t_arbitrate();
    logic [63:0] rd;
    logic [15:0] got [8];
    logic        ok;
    int          k;
    @(posedge clk);
    word12 <= 1'b0;
    for (int it = 0; it < 2; it++)
    begin
      // a processor write first hands the next tie to the io unit
      if (it == 1)
      begin
        cmfe_cpu_model_i.access(1'b1, 8'h12, 64'h0, rd, ok);
      end
      fork
        cmfe_cpu_model_i.access(1'b0, 8'h10, 64'h0, rd, ok);
        io_read(8'h11, got, k);
        begin
          repeat (3) @(posedge clk);
          check_word(64'({cpu_gnt_q, io_rd_gnt_q}), (it == 0) ? 64'h2 : 64'h1);
        end
      join
      check_word(64'(ok), 64'h1);
      check_word(rd, 64'hA5A5_0F0F_C3C3_9669);
      check_word(64'(k), 64'h4);
      check_word(64'(got[0]), 64'hFFFF);
    end
    $display("test arbitrate done");
  endtask : t_arbitrate

  task automatic mread(input logic [1:0] s, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge clk);
    maint_rd  <= 1'b1;
    maint_sel <= s;
    @(posedge clk);
    maint_rd  <= 1'b0;
    maint_sel <= ~s;
    @(posedge clk);
    check_word(64'(maint_rvalid_q), 64'h1);
    check_word(64'(maint_rdata_q & msk), 64'(exp));
  endtask : mread

  task automatic t_maint();
    @(posedge clk);
    cap_sel   <= 3'h3;
    word12    <= 1'b1;
    maint_clr <= 1'b1;
    @(posedge clk);
    maint_clr <= 1'b0;
    mread(2'h0, 32'h0, 32'hFFFF);
    mread(2'h1, 32'h0, 32'hFFFF);
    mread(2'h2, 32'h0, 32'hFF);
    mread(2'h3, 32'h70, 32'hF0);
    $display("test maint done");
  endtask : t_maint

  initial
  begin
    clk = 0; rst = 1; cap_sel = 3'h1; word12 = 0;
    pw_valid = 0; pw_data = '0; pw_addr = '0; io_rd_req = 0; io_rd_addr = '0;
    maint_rd = 0; maint_clr = 0; maint_sel = '0; errors = 0; check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_write_read();
    t_banks();
    t_pack(1'b0);
    t_pack(1'b1);
    t_split(1'b0);
    t_split(1'b1);
    t_arbitrate();
    t_maint();
    complete_run();
  end

  initial
  begin
    #(20000 * 4);
    errors++;
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
